// File: rtl/pecd_pkg.sv
// shared constants for the pin edge change detector
package pecd_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned PORT_COUNT = 4;
  // register index layout: each port owns three consecutive words
  localparam logic [3:0] PORT_STRIDE = 4'h3;
  localparam logic [3:0] RISE_OFS = 4'h0;
  localparam logic [3:0] FALL_OFS = 4'h1;
  localparam logic [3:0] FLAG_OFS = 4'h2;
  localparam logic [3:0] PORT_A_BASE = 4'h0;
  localparam logic [3:0] PORT_B_BASE = 4'h3;
  localparam logic [3:0] PORT_C_BASE = 4'h6;
  localparam logic [3:0] PORT_E_BASE = 4'h9;
  localparam logic [3:0] CTRL_OFS = 4'hC;
  // control word fields
  localparam int unsigned CTRL_MASTER_BIT = 0;
  localparam int unsigned CTRL_SUMMARY_BIT = 1;
  // implemented bit masks
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_PORT_E = 8'h08;
  localparam int unsigned PORT_E_PIN_BIT = 3;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // cycles until synchroniser and history stage hold real pin samples
  localparam logic [1:0] ARM_CYCLES = 2'h3;
endpackage : pecd_pkg

// File: rtl/pecd_port_if.sv
// register access bundle between the top and one port's edge logic
interface pecd_port_if;
  logic wrRise;
  logic wrFall;
  logic wrFlag;
  logic [7:0] wrData;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] flags;
  modport port (input wrRise, input wrFall, input wrFlag, input wrData, output rise, output fall, output flags);
  modport ctrl (output wrRise, output wrFall, output wrFlag, output wrData, input rise, input fall, input flags);
endinterface : pecd_port_if

// File: rtl/pecd_edge_port.sv
// one port: pin synchroniser, edge detect, edge enables and sticky flags
module pecd_edge_port #(
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  input wire logic clock, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic [7:0] pins, // raw pin levels
  pecd_port_if.port bus // register access
);
  logic [7:0] syncFirst;
  logic [7:0] syncSecond;
  logic [7:0] history;
  logic [1:0] armCount;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] flags;
  wire armed = (armCount == pecd_pkg::ARM_CYCLES);
  wire [7:0] riseEdge = syncSecond & ~history;
  wire [7:0] fallEdge = ~syncSecond & history;
  wire [7:0] hit;
  wire [7:0] next_rise;
  wire [7:0] next_fall;
  wire [7:0] next_flags;

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser then one history stage for edge compare
  always_ff @(posedge clock) begin
    if (reset) begin
      syncFirst <= pecd_pkg::RESET_VALUE;
      syncSecond <= pecd_pkg::RESET_VALUE;
      history <= pecd_pkg::RESET_VALUE;
    end else begin
      syncFirst <= pins;
      syncSecond <= syncFirst;
      history <= syncSecond;
    end
  end

  // hold off detection until the pipeline holds true pin levels
  always_ff @(posedge clock) begin
    if (reset) begin
      armCount <= 2'h0;
    end else if (!armed) begin
      armCount <= armCount + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // qualified edges; pins with no enable never hit
  assign hit = armed ? (((riseEdge & rise) | (fallEdge & fall)) & IMPL_MASK) : 8'h00;

  // unimplemented bits drop writes; a detected edge beats a clearing write
  assign next_rise = bus.wrRise ? (bus.wrData & IMPL_MASK) : rise;
  assign next_fall = bus.wrFall ? (bus.wrData & IMPL_MASK) : fall;
  assign next_flags = ((bus.wrFlag ? bus.wrData : flags) | hit) & IMPL_MASK;

  always_ff @(posedge clock) begin
    if (reset) begin
      rise <= pecd_pkg::RESET_VALUE;
      fall <= pecd_pkg::RESET_VALUE;
      flags <= pecd_pkg::RESET_VALUE;
    end else begin
      rise <= next_rise;
      fall <= next_fall;
      flags <= next_flags;
    end
  end

  assign bus.rise = rise;
  assign bus.fall = fall;
  assign bus.flags = flags;

  ////////////////////////////////////////////////////////////////////////
  // checks
  hit_sets_flag_a: assert property (@(posedge clock) disable iff (reset)
    (hit != 8'h00) |=> ((flags & $past(hit)) == $past(hit)))
    else $error("enabled edge did not set its flag");

  no_stray_set_a: assert property (@(posedge clock) disable iff (reset)
    !$past(bus.wrFlag) |-> ((flags & ~$past(flags)) == ($past(hit) & ~$past(flags))))
    else $error("flag set without an enabled edge");

  flag_sticky_a: assert property (@(posedge clock) disable iff (reset)
    ((~flags & $past(flags)) != 8'h00) |-> $past(bus.wrFlag))
    else $error("flag cleared without a software write");

  set_beats_clear_a: assert property (@(posedge clock) disable iff (reset)
    (bus.wrFlag && (hit != 8'h00)) |=> ((flags & $past(hit)) == $past(hit)))
    else $error("edge lost during flag clear");

  unimpl_zero_a: assert property (@(posedge clock) disable iff (reset)
    ((rise | fall | flags) & ~IMPL_MASK) == 8'h00)
    else $error("unimplemented bit reads one");

  reset_clears_a: assert property (@(posedge clock)
    $past(reset) |-> ((rise == 8'h00) && (fall == 8'h00) && (flags == 8'h00)))
    else $error("register not zero after reset");

  one_set_per_edge_a: assert property (@(posedge clock) disable iff (reset)
    (hit != 8'h00) |=> ((hit & $past(hit)) == 8'h00))
    else $error("one transition hit twice");
endmodule : pecd_edge_port

// File: rtl/pin_edge_change_detector.sv
// top: register port, four port edge blocks, summary flag and interrupt request
// Behaviour
// - port A rising-edge enables, one per pin
// - port A falling-edge enables, one per pin
// - port A flag sets only on enabled edge
// - no enables means pin never flags
// - flags stay set until software writes zero
// - flags software readable, writable, hardware settable
// - port B rising-edge enables, one per pin
// - port B falling-edge enables, one per pin
// - port B flag sets on enabled edge
// - port C rising and falling enables
// - port C flag sets on enabled edge
// - port E rising enable at bit three
// - port E other bits ignore writes, zero
// - all enables and flags reset to zero
// - port E falling enable and flag, bit three
// - summary flag is OR of all flags
// - master enable off still detects, no request
// - edge during clearing write leaves flag set
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
module pin_edge_change_detector (
  input wire logic clock, // 40 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire logic [7:0] portAPin, // port A pin levels
  input wire logic [7:0] portBPin, // port B pin levels
  input wire logic [7:0] portCPin, // port C pin levels
  input wire logic portEPin, // port E pin 3 level
  input wire logic [3:0] address, // register index
  input wire logic [7:0] writeData, // write data
  input wire logic writeStrobe, // one-cycle write
  input wire logic readStrobe, // one-cycle read
  output logic [7:0] readData, // valid the cycle after readStrobe
  output logic summaryChangeFlag, // OR of every pin flag
  output logic changeInterruptRequest // interrupt request level
);
  logic changeInterruptMasterEnable;
  logic [7:0] readBuf;
  logic [7:0] pinBus [pecd_pkg::PORT_COUNT];
  logic [7:0] flagBus [pecd_pkg::PORT_COUNT];
  logic [7:0] portRead [pecd_pkg::PORT_COUNT];
  pecd_port_if portBus [pecd_pkg::PORT_COUNT] ();

  // register index compare, shared by write and read decode
  function automatic logic addrIs(input logic [3:0] a, input logic [3:0] idx);
    addrIs = (a == idx);
  endfunction : addrIs

  ////////////////////////////////////////////////////////////////////////
  // pin routing; port E only has pin 3 wired, the rest stay low
  assign pinBus[0] = portAPin;
  assign pinBus[1] = portBPin;
  assign pinBus[2] = portCPin;
  assign pinBus[3] = {4'h0, portEPin, 3'h0};

  ////////////////////////////////////////////////////////////////////////
  // per-port decode, read select and edge block
  for (genvar g = 0; g < pecd_pkg::PORT_COUNT; g++) begin : gPort
    localparam logic [3:0] BASE = 4'(g) * pecd_pkg::PORT_STRIDE;
    localparam logic [7:0] MASK = (g == 3) ? pecd_pkg::MASK_PORT_E : pecd_pkg::MASK_FULL;
    wire selRise = addrIs(address, BASE + pecd_pkg::RISE_OFS);
    wire selFall = addrIs(address, BASE + pecd_pkg::FALL_OFS);
    wire selFlag = addrIs(address, BASE + pecd_pkg::FLAG_OFS);

    // register writes for this port
    assign portBus[g].wrRise = writeStrobe && selRise;
    assign portBus[g].wrFall = writeStrobe && selFall;
    assign portBus[g].wrFlag = writeStrobe && selFlag;
    assign portBus[g].wrData = writeData;
    assign flagBus[g] = portBus[g].flags;

    // read select; unselected words contribute zero
    assign portRead[g] = (selRise ? portBus[g].rise : 8'h00)
                       | (selFall ? portBus[g].fall : 8'h00)
                       | (selFlag ? portBus[g].flags : 8'h00);

    pecd_edge_port #(
      .IMPL_MASK(MASK)
    ) uPort (
      .clock(clock),
      .reset(reset),
      .pins(pinBus[g]),
      .bus(portBus[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // summary and request; detection runs regardless of the master enable
  assign summaryChangeFlag = |{flagBus[0], flagBus[1], flagBus[2], flagBus[3]};
  assign changeInterruptRequest = changeInterruptMasterEnable && summaryChangeFlag;

  // control word: master enable is the only writable bit
  wire selCtrl = addrIs(address, pecd_pkg::CTRL_OFS);
  wire [7:0] ctrlRead = selCtrl ? {6'h00, summaryChangeFlag, changeInterruptMasterEnable} : 8'h00;
  wire [7:0] next_readBuf = portRead[0] | portRead[1] | portRead[2] | portRead[3] | ctrlRead;

  always_ff @(posedge clock) begin
    if (reset) begin
      changeInterruptMasterEnable <= 1'b0;
    end else if (writeStrobe && selCtrl) begin
      changeInterruptMasterEnable <= writeData[pecd_pkg::CTRL_MASTER_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock) begin
    if (reset) begin
      readBuf <= pecd_pkg::RESET_VALUE;
    end else begin
      readBuf <= readStrobe ? next_readBuf : 8'h00;
    end
  end
  assign readData = readBuf;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence ctrlReadReq;
    readStrobe && selCtrl;
  endsequence

  sequence flagWriteReq;
    writeStrobe && addrIs(address, pecd_pkg::PORT_A_BASE + pecd_pkg::FLAG_OFS) && (writeData == 8'h00);
  endsequence

  irq_gating_a: assert property (@(posedge clock) disable iff (reset)
    changeInterruptRequest == (changeInterruptMasterEnable && (flagBus[0] != 8'h00 || flagBus[1] != 8'h00
      || flagBus[2] != 8'h00 || flagBus[3] != 8'h00)))
    else $error("request not master enable and any flag");

  summary_or_a: assert property (@(posedge clock) disable iff (reset)
    summaryChangeFlag == ((flagBus[0] | flagBus[1] | flagBus[2] | flagBus[3]) != 8'h00))
    else $error("summary flag wrong");

  irq_masked_a: assert property (@(posedge clock) disable iff (reset)
    !changeInterruptMasterEnable |-> !changeInterruptRequest)
    else $error("request raised while master enable clear");

  ctrl_read_a: assert property (@(posedge clock) disable iff (reset)
    ctrlReadReq |=> (readData[pecd_pkg::CTRL_SUMMARY_BIT:0]
      == {$past(summaryChangeFlag), $past(changeInterruptMasterEnable)}) ##1 (readData == 8'h00 || $past(readStrobe)))
    else $error("control read wrong");

  flag_clear_a: assert property (@(posedge clock) disable iff (reset)
    flagWriteReq ##1 (portBus[0].flags == 8'h00) ##1 readStrobe
      && addrIs(address, pecd_pkg::PORT_A_BASE + pecd_pkg::FLAG_OFS)
      |=> (readData == $past(portBus[0].flags)))
    else $error("port A flag read after clear wrong");

  port_e_read_a: assert property (@(posedge clock) disable iff (reset)
    readStrobe && addrIs(address, pecd_pkg::PORT_E_BASE + pecd_pkg::RISE_OFS)
      |=> ((readData & ~pecd_pkg::MASK_PORT_E) == 8'h00))
    else $error("port E unimplemented bit reads one");
endmodule : pin_edge_change_detector

// File: bench/pecd_pin_model.sv
// outside driver for the general-purpose pins seen by the edge detector
module pecd_pin_model (
  input wire logic clock, // system clock
  input wire logic load, // take new levels at the next edge
  input wire logic [24:0] level, // wanted levels: E pin 3, C, B, A
  output logic [7:0] portAPin, // port A pin levels
  output logic [7:0] portBPin, // port B pin levels
  output logic [7:0] portCPin, // port C pin levels
  output logic portEPin // port E pin 3 level
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////
  // levels hold between loads; a pin never floats, so no unknown reaches the design
  initial begin
    {portEPin, portCPin, portBPin, portAPin} = 25'h0000000;
  end
  always @(posedge clock) begin
    if (load) begin
      {portEPin, portCPin, portBPin, portAPin} <= level;
    end
  end
endmodule : pecd_pin_model

// File: bench/pin_edge_change_detector_test.sv
// self-checking bench for the pin edge change detector
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module pin_edge_change_detector_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, writeStrobe, readStrobe, load, summaryChangeFlag, changeInterruptRequest, portEPin;
  logic [7:0] portAPin, portBPin, portCPin, writeData, readData, got, r;
  logic [3:0] address;
  logic [24:0] level;
  logic [7:0] expFlag[4], pinOld[4], pinNew[4], riseEn[4], fallEn[4];
  logic master, expSum;
  int n_mismatch, total_checks;
  pin_edge_change_detector i_pin_edge_change_detector (.clock(clock), .reset(reset), .portAPin(portAPin),
    .portBPin(portBPin), .portCPin(portCPin), .portEPin(portEPin), .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .summaryChangeFlag(summaryChangeFlag), .changeInterruptRequest(changeInterruptRequest));
  pecd_pin_model i_pecd_pin_model (.clock(clock), .load(load), .level(level), .portAPin(portAPin),
    .portBPin(portBPin), .portCPin(portCPin), .portEPin(portEPin));
  ////////////////////////////////////////////////////////////////////////
  // expectation helpers: implemented bits and enabled edges
  function automatic logic [7:0] msk(input int p);
    return (p == 3) ? 8'h08 : 8'hFF;
  endfunction : msk
  function automatic logic [7:0] hit(input logic [7:0] ri, fa, o, n);
    return (ri & ~o & n) | (fa & o & ~n);
  endfunction : hit
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe, so sample just after that edge
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 got = readData;
    `CHK(got, e)
  endtask : chk_rd
  task automatic check_idle();
    for (int a = 0; a < 16; a++) chk_rd(4'(a), 8'h00);
    `CHK(summaryChangeFlag, 1'b0)
  endtask : check_idle
  // new pin levels appear one edge after the load
  task automatic drive_pins(input int n);
    @(posedge clock);
    level <= {pinNew[3][3], pinNew[2], pinNew[1], pinNew[0]};
    load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
    repeat (n) @(posedge clock);
    for (int p = 0; p < 4; p++) pinOld[p] = pinNew[p];
  endtask : drive_pins
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    close_out();
  end
  initial begin
    reset = 1'b1; writeStrobe = 1'b0; readStrobe = 1'b0; load = 1'b0;
    level = 25'h0000000; address = 4'h0; writeData = 8'h00;
    for (int p = 0; p < 4; p++) begin
      pinOld[p] = 8'h00; pinNew[p] = 8'h00; expFlag[p] = 8'h00;
    end
    void'($urandom(32'hDEE8));
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    check_idle();
    // all ones everywhere: unimplemented bits and unmapped words stay zero
    for (int a = 0; a < 16; a++) wr(4'(a), 8'hFF);
    for (int a = 0; a < 16; a++) chk_rd(4'(a), a > 12 ? 8'h00 : a == 12 ? 8'h03 : a >= 9 ? 8'h08 : 8'hFF);
    `CHK(changeInterruptRequest, 1'b1)
    for (int a = 0; a < 13; a++) wr(4'(a), 8'h00);
    wr(4'h2, 8'h00);
    chk_rd(4'h2, 8'h00);
    check_idle();
    // random enables, master and pin moves; first pass no enables, second all toggling
    for (int i = 0; i < 30; i++) begin
      for (int p = 0; p < 4; p++) begin
        r = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
        wr(4'(3 * p), r);
        riseEn[p] = r & msk(p);
        r = (i < 2) ? r : (8'($urandom) & r) ^ (8'($urandom) & ~r);
        wr(4'(3 * p + 1), r);
        fallEn[p] = r & msk(p);
        pinNew[p] = ((i < 2) ? ~pinOld[p] : 8'($urandom)) & msk(p);
      end
      master = 1'($urandom);
      wr(4'hC, {7'h00, master});
      // enables as now stored, read back before the pins move
      for (int p = 0; p < 4; p++) begin
        chk_rd(4'(3 * p), riseEn[p]);
        chk_rd(4'(3 * p + 1), fallEn[p]);
        // first pass has no enables at all, so its flags must stay clear
        expFlag[p] = expFlag[p] | hit(riseEn[p], fallEn[p], pinOld[p], pinNew[p]);
      end
      drive_pins(5);
      expSum = |{expFlag[0], expFlag[1], expFlag[2], expFlag[3]};
      `CHK(summaryChangeFlag, expSum)
      `CHK(changeInterruptRequest, expSum & master)
      for (int p = 0; p < 4; p++) chk_rd(4'(3 * p + 2), expFlag[p]);
      chk_rd(4'hC, {6'h00, expSum, master});
      if (1'($urandom)) begin
        for (int p = 0; p < 4; p++) begin
          r = 8'($urandom);
          wr(4'(3 * p + 2), r);
          expFlag[p] = r & msk(p);
        end
      end
    end
    // rising edge lands in the same cycle as a clearing write
    pinNew[0] = pinOld[0] & 8'hFE;
    drive_pins(4);
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h00);
    pinNew[0][0] = 1'b1;
    drive_pins(1);
    wr(4'h2, 8'h00);
    chk_rd(4'h2, 8'h01);
    // second reset in mid-run clears everything again
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    check_idle();
    close_out();
  end
endmodule : pin_edge_change_detector_test
